/* rtl/brx_pkg.sv */
// Shared constants and types for the branch, skip, bit and shift execution unit
package brx_pkg;
  localparam int PC_W = 12;
  localparam int K_W = 7;
  // Status flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  // Cycle counts
  localparam logic [1:0] CYC_FALL = 2'h1;
  localparam logic [1:0] CYC_BRANCH = 2'h2;
  localparam logic [1:0] CYC_SKIP_ONE = 2'h2;
  localparam logic [1:0] CYC_SKIP_TWO = 2'h3;
  localparam logic [1:0] CYC_IOBIT = 2'h2;
  localparam logic [1:0] CYC_SHIFT = 2'h1;
  // Reset values
  localparam logic [PC_W-1:0] PC_RESET = 12'h000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [5:0] IO_ADDR_RESET = 6'h00;

  typedef enum logic [4:0] {
    BRX_NOP,
    SKIP_IF_REG_BIT_SET, SKIP_IF_REG_BIT_CLEAR, SKIP_IF_IO_BIT_CLEAR, SKIP_IF_IO_BIT_SET,
    BRANCH_IF_FLAG_SET, BRANCH_IF_FLAG_CLEAR, BRANCH_IF_EQUAL, BRANCH_IF_NOT_EQUAL,
    BRANCH_IF_CARRY_SET, BRANCH_IF_CARRY_CLEAR, BRANCH_IF_SAME_OR_HIGHER, BRANCH_IF_LOWER,
    BRANCH_IF_MINUS, BRANCH_IF_PLUS, BRANCH_IF_SIGNED_GE, BRANCH_IF_SIGNED_LT,
    BRANCH_IF_HALFCARRY_SET, BRANCH_IF_HALFCARRY_CLEAR, BRANCH_IF_TBIT_SET, BRANCH_IF_TBIT_CLEAR,
    BRANCH_IF_OVERFLOW_SET, BRANCH_IF_OVERFLOW_CLEAR, BRANCH_IF_IRQ_ENABLED, BRANCH_IF_IRQ_DISABLED,
    SET_IO_BIT, CLEAR_IO_BIT, LOGICAL_SHIFT_LEFT, LOGICAL_SHIFT_RIGHT
  } brx_op_e;

  typedef enum logic [2:0] {KIND_NONE, KIND_SKIP, KIND_BRANCH, KIND_IOBIT, KIND_SHIFT} brx_kind_e;

  function automatic brx_kind_e brx_kind(input brx_op_e op);
    brx_kind_e k;
    k = KIND_NONE;
    if (op >= SKIP_IF_REG_BIT_SET && op <= SKIP_IF_IO_BIT_SET) k = KIND_SKIP;
    else if (op >= BRANCH_IF_FLAG_SET && op <= BRANCH_IF_IRQ_DISABLED) k = KIND_BRANCH;
    else if (op == SET_IO_BIT || op == CLEAR_IO_BIT) k = KIND_IOBIT;
    else if (op == LOGICAL_SHIFT_LEFT || op == LOGICAL_SHIFT_RIGHT) k = KIND_SHIFT;
    return k;
  endfunction : brx_kind
endpackage : brx_pkg

/* rtl/brx_cond_if.sv */
// Interface between the sequencer and the condition and shift evaluator
`timescale 1ns/1ps
interface brx_cond_if;
  brx_pkg::brx_op_e op;
  logic [2:0] bit_sel;
  logic [7:0] reg_value;
  logic [7:0] io_value;
  logic [7:0] status;
  logic cond;
  logic [7:0] shift_res;
  logic [7:0] shift_status;
  modport eval (input op, bit_sel, reg_value, io_value, status, output cond, shift_res, shift_status);
  modport use_side (output op, bit_sel, reg_value, io_value, status, input cond, shift_res, shift_status);
endinterface : brx_cond_if

/* rtl/brx_cond.sv */
// Condition evaluation for skips and branches, and shift results with flags
`timescale 1ns/1ps
module brx_cond (
  brx_cond_if.eval cif
);
  logic [7:0] st;
  logic [7:0] rv;
  logic c_new;
  logic n_new;
  logic v_new;
  assign st = cif.status;
  assign rv = cif.reg_value;

  always_comb begin
    case (cif.op)
      brx_pkg::SKIP_IF_REG_BIT_SET: cif.cond = rv[cif.bit_sel]; // RULE1
      brx_pkg::SKIP_IF_REG_BIT_CLEAR: cif.cond = ~rv[cif.bit_sel]; // RULE1
      brx_pkg::SKIP_IF_IO_BIT_CLEAR: cif.cond = ~cif.io_value[cif.bit_sel]; // RULE2
      brx_pkg::SKIP_IF_IO_BIT_SET: cif.cond = cif.io_value[cif.bit_sel]; // RULE2
      brx_pkg::BRANCH_IF_FLAG_SET: cif.cond = st[cif.bit_sel]; // RULE3
      brx_pkg::BRANCH_IF_FLAG_CLEAR: cif.cond = ~st[cif.bit_sel]; // RULE3
      brx_pkg::BRANCH_IF_EQUAL: cif.cond = st[brx_pkg::FLAG_Z]; // RULE6
      brx_pkg::BRANCH_IF_NOT_EQUAL: cif.cond = ~st[brx_pkg::FLAG_Z]; // RULE6
      brx_pkg::BRANCH_IF_CARRY_SET, brx_pkg::BRANCH_IF_LOWER: cif.cond = st[brx_pkg::FLAG_C]; // RULE5
      brx_pkg::BRANCH_IF_CARRY_CLEAR, brx_pkg::BRANCH_IF_SAME_OR_HIGHER: cif.cond = ~st[brx_pkg::FLAG_C]; // RULE5
      brx_pkg::BRANCH_IF_MINUS: cif.cond = st[brx_pkg::FLAG_N]; // RULE6
      brx_pkg::BRANCH_IF_PLUS: cif.cond = ~st[brx_pkg::FLAG_N]; // RULE6
      brx_pkg::BRANCH_IF_SIGNED_GE: cif.cond = ~(st[brx_pkg::FLAG_N] ^ st[brx_pkg::FLAG_V]); // RULE7
      brx_pkg::BRANCH_IF_SIGNED_LT: cif.cond = st[brx_pkg::FLAG_N] ^ st[brx_pkg::FLAG_V]; // RULE7
      brx_pkg::BRANCH_IF_HALFCARRY_SET: cif.cond = st[brx_pkg::FLAG_H]; // RULE8
      brx_pkg::BRANCH_IF_HALFCARRY_CLEAR: cif.cond = ~st[brx_pkg::FLAG_H]; // RULE8
      brx_pkg::BRANCH_IF_TBIT_SET: cif.cond = st[brx_pkg::FLAG_T]; // RULE9
      brx_pkg::BRANCH_IF_TBIT_CLEAR: cif.cond = ~st[brx_pkg::FLAG_T]; // RULE9
      brx_pkg::BRANCH_IF_OVERFLOW_SET: cif.cond = st[brx_pkg::FLAG_V]; // RULE10
      brx_pkg::BRANCH_IF_OVERFLOW_CLEAR: cif.cond = ~st[brx_pkg::FLAG_V]; // RULE10
      brx_pkg::BRANCH_IF_IRQ_ENABLED: cif.cond = st[brx_pkg::FLAG_I]; // RULE11
      brx_pkg::BRANCH_IF_IRQ_DISABLED: cif.cond = ~st[brx_pkg::FLAG_I]; // RULE11
      default: cif.cond = 1'b0;
    endcase
  end

  // Shift result and the four flags it touches; H, S, T, I pass through
  always_comb begin
    if (cif.op == brx_pkg::LOGICAL_SHIFT_LEFT) begin
      cif.shift_res = {rv[6:0], 1'b0}; // RULE14
      c_new = rv[7];
      n_new = rv[6];
    end else begin
      cif.shift_res = {1'b0, rv[7:1]}; // RULE15
      c_new = rv[0];
      n_new = 1'b0;
    end
    v_new = n_new ^ c_new;
    cif.shift_status = st;
    cif.shift_status[brx_pkg::FLAG_C] = c_new; // RULE14
    cif.shift_status[brx_pkg::FLAG_N] = n_new; // RULE14
    cif.shift_status[brx_pkg::FLAG_V] = v_new; // RULE15
    cif.shift_status[brx_pkg::FLAG_Z] = (cif.shift_res == 8'h00); // RULE15
  end
endmodule : brx_cond

/* rtl/brx_exec.sv */
// Sequencer for skips, relative branches, I/O bit set/clear and logical shifts
//
// Behaviour
// RULE1: Register-bit skip tests bit b; skips next, PC+2 or +3, 1/2/3 cycles, flags kept.
// RULE2: I/O-bit skip tests bit b of port P; 1/2/3 cycles, no flag change.
// RULE3: Generic flag branch picks flag s; taken loads PC+k+1.
// RULE4: Untaken branch continues in 1 cycle; taken takes 2; no flags modified.
// RULE5: Carry branches: set/lower on C=1, clear/same-or-higher on C=0.
// RULE6: Equal/not-equal test Z; minus/plus test N.
// RULE7: Signed ge taken when N xor V is 0, lt when 1.
// RULE8: Half-carry branches taken on H=1 or H=0.
// RULE9: T-bit branches taken on T=1 or T=0, else fall through.
// RULE10: Overflow branches taken on V=1 or V=0.
// RULE11: Interrupt-state branches taken on I=1 or I=0.
// RULE12: Set I/O bit forces bit b to 1, others kept, 2 cycles.
// RULE13: Clear I/O bit forces bit b to 0, others kept, 2 cycles.
// RULE14: Shift left inserts 0 at bit 0, updates Z C N V, 1 cycle.
// RULE15: Shift right inserts 0 at bit 7, updates Z C N V, 1 cycle.
// RULE16: Offset k is signed, sign-extended to PC width, added with one.
`timescale 1ns/1ps
module brx_exec (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire brx_pkg::brx_op_e instr_op,
  input wire logic [2:0] bit_sel,
  input wire logic [brx_pkg::K_W-1:0] offset_k,
  input wire logic [brx_pkg::PC_W-1:0] pc_in,
  input wire logic next_two_word,
  input wire logic [7:0] reg_value,
  input wire logic [7:0] io_value,
  input wire logic [5:0] io_addr,
  input wire logic [7:0] status_in,
  output logic busy,
  output logic done,
  output logic [brx_pkg::PC_W-1:0] pc_next,
  output logic io_wr,
  output logic [5:0] io_waddr,
  output logic [7:0] io_wdata,
  output logic rd_wr,
  output logic [7:0] rd_wdata,
  output logic status_wr,
  output logic [7:0] status_out
);
  typedef enum logic {ST_IDLE, ST_WAIT} brx_state_e;

  function automatic logic [7:0] bit_mask(input logic [2:0] b);
    return 8'h01 << b;
  endfunction : bit_mask

  logic rst_meta_reg;
  logic rst_sync_n_reg;
  brx_state_e state_reg;
  logic [1:0] cnt_reg;
  brx_pkg::brx_op_e op_reg;
  logic [2:0] bit_reg;
  logic busy_reg;
  logic done_reg;
  logic io_wr_reg;
  logic rd_wr_reg;
  logic status_wr_reg;
  logic [brx_pkg::PC_W-1:0] pc_next_reg;
  logic [5:0] io_waddr_reg;
  logic [7:0] io_wdata_reg;
  logic [7:0] rd_wdata_reg;
  logic [7:0] status_out_reg;
  logic accept;
  logic [1:0] cycles;
  logic [brx_pkg::PC_W-1:0] target;
  logic [brx_pkg::PC_W-1:0] k_ext;
  logic done_next;
  brx_pkg::brx_kind_e kind_in;
  brx_pkg::brx_kind_e kind_done;

  brx_cond_if cif ();
  brx_cond u_cond (.cif(cif));
  assign cif.op = instr_op;
  assign cif.bit_sel = bit_sel;
  assign cif.reg_value = reg_value;
  assign cif.io_value = io_value;
  assign cif.status = status_in;

  // Reset release synchroniser
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n_reg <= rst_meta_reg;
    end
  end

  assign accept = instr_valid && (state_reg == ST_IDLE);
  assign kind_in = brx_pkg::brx_kind(instr_op);
  assign k_ext = {{(brx_pkg::PC_W-brx_pkg::K_W){offset_k[brx_pkg::K_W-1]}}, offset_k}; // RULE16

  // Cycle count and next PC of the incoming instruction
  always_comb begin
    cycles = brx_pkg::CYC_FALL;
    target = pc_in + 12'h001;
    case (kind_in)
      brx_pkg::KIND_SKIP: begin
        if (cif.cond) begin
          cycles = next_two_word ? brx_pkg::CYC_SKIP_TWO : brx_pkg::CYC_SKIP_ONE; // RULE1 RULE2
          target = pc_in + (next_two_word ? 12'h003 : 12'h002); // RULE1 RULE2
        end
      end
      brx_pkg::KIND_BRANCH: begin
        if (cif.cond) begin
          cycles = brx_pkg::CYC_BRANCH; // RULE4
          target = pc_in + k_ext + 12'h001; // RULE3 RULE16
        end
      end
      brx_pkg::KIND_IOBIT: cycles = brx_pkg::CYC_IOBIT; // RULE12 RULE13
      brx_pkg::KIND_SHIFT: cycles = brx_pkg::CYC_SHIFT; // RULE14 RULE15
      default: cycles = brx_pkg::CYC_FALL;
    endcase
  end

  assign done_next = (accept && cycles == brx_pkg::CYC_FALL) || (state_reg == ST_WAIT && cnt_reg == 2'h1);
  assign kind_done = (state_reg == ST_WAIT) ? brx_pkg::brx_kind(op_reg) : kind_in;

  // Sequencing of multi-cycle instructions
  always_ff @(posedge sys_clk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 2'h0;
      busy_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (accept && cycles != brx_pkg::CYC_FALL) begin
            state_reg <= ST_WAIT;
            cnt_reg <= cycles - 2'h1;
            busy_reg <= 1'b1;
          end
        end
        ST_WAIT: begin
          cnt_reg <= cnt_reg - 2'h1;
          if (cnt_reg == 2'h1) begin
            state_reg <= ST_IDLE;
            busy_reg <= 1'b0;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Result capture at acceptance
  always_ff @(posedge sys_clk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      op_reg <= brx_pkg::BRX_NOP;
      bit_reg <= 3'h0;
      pc_next_reg <= brx_pkg::PC_RESET;
      io_waddr_reg <= brx_pkg::IO_ADDR_RESET;
      io_wdata_reg <= brx_pkg::BYTE_RESET;
      rd_wdata_reg <= brx_pkg::BYTE_RESET;
      status_out_reg <= brx_pkg::BYTE_RESET;
    end else if (accept) begin
      op_reg <= instr_op;
      bit_reg <= bit_sel;
      pc_next_reg <= target;
      io_waddr_reg <= io_addr;
      if (instr_op == brx_pkg::SET_IO_BIT) io_wdata_reg <= io_value | bit_mask(bit_sel); // RULE12
      else io_wdata_reg <= io_value & ~bit_mask(bit_sel); // RULE13
      rd_wdata_reg <= cif.shift_res;
      status_out_reg <= cif.shift_status;
    end
  end

  // Completion strobes
  always_ff @(posedge sys_clk or negedge rst_sync_n_reg) begin
    if (!rst_sync_n_reg) begin
      done_reg <= 1'b0;
      io_wr_reg <= 1'b0;
      rd_wr_reg <= 1'b0;
      status_wr_reg <= 1'b0;
    end else begin
      done_reg <= done_next;
      io_wr_reg <= done_next && kind_done == brx_pkg::KIND_IOBIT; // RULE12 RULE13
      rd_wr_reg <= done_next && kind_done == brx_pkg::KIND_SHIFT;
      status_wr_reg <= done_next && kind_done == brx_pkg::KIND_SHIFT; // RULE4 RULE14
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;
  assign pc_next = pc_next_reg;
  assign io_wr = io_wr_reg;
  assign io_waddr = io_waddr_reg;
  assign io_wdata = io_wdata_reg;
  assign rd_wr = rd_wr_reg;
  assign rd_wdata = rd_wdata_reg;
  assign status_wr = status_wr_reg;
  assign status_out = status_out_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_sync_n_reg);

  a_shift_left_fill: assert property (rd_wr && op_reg == brx_pkg::LOGICAL_SHIFT_LEFT |-> // RULE14
    rd_wdata[0] == 1'b0 && status_out[brx_pkg::FLAG_C] == $past(reg_value[7], 1) && !$past(busy))
    else $error("shift left result or carry wrong");
  a_shift_right_fill: assert property (accept && instr_op == brx_pkg::LOGICAL_SHIFT_RIGHT |=> // RULE15
    rd_wr && rd_wdata == {1'b0, $past(reg_value[7:1])} && status_out[brx_pkg::FLAG_N] == 1'b0)
    else $error("shift right result wrong");
  a_branch_not_taken: assert property (accept && kind_in == brx_pkg::KIND_BRANCH && !cif.cond |=> // RULE4
    done && pc_next == $past(pc_in) + 12'h001)
    else $error("untaken branch not sequential in one cycle");
  a_branch_taken_two: assert property (accept && kind_in == brx_pkg::KIND_BRANCH && cif.cond |=> // RULE16
    !done ##1 done && pc_next == $past(pc_in, 2) + {{5{$past(offset_k[6], 2)}}, $past(offset_k, 2)} + 12'h001)
    else $error("taken branch target or timing wrong");
  a_skip_two_word: assert property (accept && kind_in == brx_pkg::KIND_SKIP && cif.cond && next_two_word |=> // RULE1
    (!done && busy) [*2] ##1 done && pc_next == $past(pc_in, 3) + 12'h003)
    else $error("skip over two-word instruction wrong");
  a_io_set_bit: assert property (accept && instr_op == brx_pkg::SET_IO_BIT |=> // RULE12
    !io_wr ##1 io_wr && io_wdata == ($past(io_value, 2) | (8'h01 << $past(bit_sel, 2))))
    else $error("set io bit value or timing wrong");
  a_io_clear_bit: assert property (io_wr && op_reg == brx_pkg::CLEAR_IO_BIT |-> // RULE13
    io_wdata[bit_reg] == 1'b0 && $past(busy))
    else $error("clear io bit wrong");
  a_no_flag_write: assert property (done && brx_pkg::brx_kind(op_reg) != brx_pkg::KIND_SHIFT |-> // RULE2
    !status_wr)
    else $error("flags written by non-shift instruction");
  a_signed_compare: assert property (accept && instr_op == brx_pkg::BRANCH_IF_SIGNED_LT |-> // RULE7
    cycles == (status_in[brx_pkg::FLAG_N] ^ status_in[brx_pkg::FLAG_V] ? 2'h2 : 2'h1))
    else $error("signed less-than decision wrong");
endmodule : brx_exec

/* bench/brx_far_model.sv */
// Far-side model: program counter, working register, I/O register and status flags
`timescale 1ns/1ps
module brx_far_model (
  input wire logic sys_clk,
  input wire logic done,
  input wire logic [brx_pkg::PC_W-1:0] pc_next,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  input wire logic rd_wr,
  input wire logic [7:0] rd_wdata,
  input wire logic status_wr,
  input wire logic [7:0] status_out,
  output logic [brx_pkg::PC_W-1:0] pc_q,
  output logic [7:0] reg_q,
  output logic [7:0] io_q,
  output logic [7:0] status_q
);
  initial begin
    pc_q = brx_pkg::PC_RESET;
    reg_q = 8'h00;
    io_q = 8'h00;
    status_q = 8'h00;
  end
  // Write-backs land at the edge after each pulse
  always @(posedge sys_clk) begin
    if (done) begin
      pc_q <= pc_next;
    end
    if (io_wr) begin
      io_q <= io_wdata;
    end
    if (rd_wr) begin
      reg_q <= rd_wdata;
    end
    if (status_wr) begin
      status_q <= status_out;
    end
  end
endmodule : brx_far_model

/* bench/branch_skip_bitop_exec_tb_top.sv */
// Self-checking testbench for the branch, skip, bit and shift unit
`timescale 1ns/1ps
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin fail_count++; $display("BAD %0t %s", $time, m); end end
module branch_skip_bitop_exec_tb_top;
  logic sys_clk, reset_n, instr_valid, next_two_word, busy, done, io_wr, rd_wr, status_wr;
  brx_pkg::brx_op_e instr_op;
  logic [2:0] bit_sel;
  logic [brx_pkg::K_W-1:0] offset_k;
  logic [5:0] io_addr, io_waddr;
  logic [brx_pkg::PC_W-1:0] pc_in, pc_next;
  logic [7:0] reg_value, io_value, status_in, io_wdata, rd_wdata, status_out;
  int fail_count, check_count, seed;

  brx_exec DUT (.sys_clk(sys_clk), .reset_n(reset_n), .instr_valid(instr_valid), .instr_op(instr_op),
    .bit_sel(bit_sel), .offset_k(offset_k), .pc_in(pc_in), .next_two_word(next_two_word),
    .reg_value(reg_value), .io_value(io_value), .io_addr(io_addr), .status_in(status_in), .busy(busy),
    .done(done), .pc_next(pc_next), .io_wr(io_wr), .io_waddr(io_waddr), .io_wdata(io_wdata), .rd_wr(rd_wr),
    .rd_wdata(rd_wdata), .status_wr(status_wr), .status_out(status_out));

  brx_far_model far (.sys_clk(sys_clk), .done(done), .pc_next(pc_next), .io_wr(io_wr), .io_wdata(io_wdata),
    .rd_wr(rd_wr), .rd_wdata(rd_wdata), .status_wr(status_wr), .status_out(status_out), .pc_q(pc_in),
    .reg_q(reg_value), .io_q(io_value), .status_q(status_in));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Expected condition for each skip and branch
  function automatic logic cond_exp(brx_pkg::brx_op_e op, logic [2:0] b, logic [7:0] r, logic [7:0] io,
                                    logic [7:0] s);
    case (op)
      brx_pkg::SKIP_IF_REG_BIT_SET: return r[b];
      brx_pkg::SKIP_IF_REG_BIT_CLEAR: return !r[b];
      brx_pkg::SKIP_IF_IO_BIT_CLEAR: return !io[b];
      brx_pkg::SKIP_IF_IO_BIT_SET: return io[b];
      brx_pkg::BRANCH_IF_FLAG_SET: return s[b];
      brx_pkg::BRANCH_IF_FLAG_CLEAR: return !s[b];
      brx_pkg::BRANCH_IF_EQUAL: return s[brx_pkg::FLAG_Z];
      brx_pkg::BRANCH_IF_NOT_EQUAL: return !s[brx_pkg::FLAG_Z];
      brx_pkg::BRANCH_IF_CARRY_SET, brx_pkg::BRANCH_IF_LOWER: return s[brx_pkg::FLAG_C];
      brx_pkg::BRANCH_IF_CARRY_CLEAR, brx_pkg::BRANCH_IF_SAME_OR_HIGHER: return !s[brx_pkg::FLAG_C];
      brx_pkg::BRANCH_IF_MINUS: return s[brx_pkg::FLAG_N];
      brx_pkg::BRANCH_IF_PLUS: return !s[brx_pkg::FLAG_N];
      brx_pkg::BRANCH_IF_SIGNED_GE: return !(s[brx_pkg::FLAG_N] ^ s[brx_pkg::FLAG_V]);
      brx_pkg::BRANCH_IF_SIGNED_LT: return s[brx_pkg::FLAG_N] ^ s[brx_pkg::FLAG_V];
      brx_pkg::BRANCH_IF_HALFCARRY_SET: return s[brx_pkg::FLAG_H];
      brx_pkg::BRANCH_IF_HALFCARRY_CLEAR: return !s[brx_pkg::FLAG_H];
      brx_pkg::BRANCH_IF_TBIT_SET: return s[brx_pkg::FLAG_T];
      brx_pkg::BRANCH_IF_TBIT_CLEAR: return !s[brx_pkg::FLAG_T];
      brx_pkg::BRANCH_IF_OVERFLOW_SET: return s[brx_pkg::FLAG_V];
      brx_pkg::BRANCH_IF_OVERFLOW_CLEAR: return !s[brx_pkg::FLAG_V];
      brx_pkg::BRANCH_IF_IRQ_ENABLED: return s[brx_pkg::FLAG_I];
      brx_pkg::BRANCH_IF_IRQ_DISABLED: return !s[brx_pkg::FLAG_I];
      default: return 1'b0;
    endcase
  endfunction : cond_exp

  task automatic stop_test();
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  // Offers one instruction at a falling edge and checks it through to done
  task automatic run_op(brx_pkg::brx_op_e op, logic [2:0] b, logic [6:0] k, logic ntw, logic [7:0] st);
    logic c, is_skip, is_br, is_io, is_sh;
    logic [7:0] r, io, exp_res, exp_st, exp_io;
    logic [brx_pkg::PC_W-1:0] pc, exp_pc;
    int n, exp_n;
    r = 8'($random(seed));
    io = 8'($random(seed));
    pc = 12'($random(seed));
    far.pc_q = pc;
    far.reg_q = r;
    far.io_q = io;
    far.status_q = st;
    is_skip = op >= brx_pkg::SKIP_IF_REG_BIT_SET && op <= brx_pkg::SKIP_IF_IO_BIT_SET;
    is_br = op >= brx_pkg::BRANCH_IF_FLAG_SET && op <= brx_pkg::BRANCH_IF_IRQ_DISABLED;
    is_io = op == brx_pkg::SET_IO_BIT || op == brx_pkg::CLEAR_IO_BIT;
    is_sh = op == brx_pkg::LOGICAL_SHIFT_LEFT || op == brx_pkg::LOGICAL_SHIFT_RIGHT;
    c = cond_exp(op, b, r, io, st);
    exp_n = is_io ? 2 : 1;
    exp_pc = pc + 12'h001;
    if (is_br && c) begin
      exp_n = 2;
      exp_pc = pc + {{5{k[6]}}, k} + 12'h001;
    end
    if (is_skip && c) begin
      exp_n = ntw ? 3 : 2;
      exp_pc = pc + (ntw ? 12'h003 : 12'h002);
    end
    exp_io = (op == brx_pkg::SET_IO_BIT) ? (io | (8'h01 << b)) : (io & ~(8'h01 << b));
    exp_res = (op == brx_pkg::LOGICAL_SHIFT_LEFT) ? {r[6:0], 1'b0} : {1'b0, r[7:1]};
    exp_st = st;
    exp_st[brx_pkg::FLAG_C] = (op == brx_pkg::LOGICAL_SHIFT_LEFT) ? r[7] : r[0];
    exp_st[brx_pkg::FLAG_Z] = exp_res == 8'h00;
    exp_st[brx_pkg::FLAG_N] = exp_res[7];
    exp_st[brx_pkg::FLAG_V] = exp_res[7] ^ exp_st[brx_pkg::FLAG_C];
    instr_op = op;
    bit_sel = b;
    offset_k = k;
    next_two_word = ntw;
    io_addr = 6'($random(seed));
    instr_valid = 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      @(negedge sys_clk);
      n++;
      if (n == 1 && done !== 1'b1 && k[0]) instr_valid = 1'b0;
      if (done !== 1'b1) `CHK({busy, io_wr, rd_wr, status_wr}, 4'h8, "busy low or stray write")
    end while (done !== 1'b1 && n < 6);
    `CHK(n, exp_n, "cycle count")
    `CHK(pc_next, exp_pc, "next pc")
    `CHK({io_wr, rd_wr, status_wr}, {is_io, is_sh, is_sh}, "write strobes")
    if (is_io) `CHK({io_waddr, io_wdata}, {io_addr, exp_io}, "io write")
    if (is_sh) `CHK({rd_wdata, status_out}, {exp_res, exp_st}, "shift result")
    if (done !== 1'b1) stop_test();
  endtask : run_op

  initial begin
    fail_count = 0;
    check_count = 0;
    seed = 64482;
    reset_n = 1'b0;
    instr_valid = 1'b0;
    instr_op = brx_pkg::BRX_NOP;
    bit_sel = 3'h0;
    offset_k = 7'h00;
    next_two_word = 1'b0;
    io_addr = 6'h00;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    // Every opcode with all flags clear, then all set, at offset extremes
    for (int p = 0; p < 2; p++) begin
      for (int o = 0; o < 29; o++) begin
        run_op(brx_pkg::brx_op_e'(o), 3'(o), p ? 7'h3f : 7'h40, 1'(p), p ? 8'hff : 8'h00);
      end
    end
    // Mid-run reset clears every output
    instr_valid = 1'b0;
    reset_n = 1'b0;
    @(negedge sys_clk);
    `CHK({busy, done, io_wr, rd_wr, status_wr, pc_next, io_waddr, io_wdata, rd_wdata, status_out}, 47'h0, "reset")
    reset_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    for (int i = 0; i < 400; i++) begin
      run_op(brx_pkg::brx_op_e'(5'($unsigned($random(seed)) % 29)), 3'($random(seed)), 7'($random(seed)),
             1'($random(seed)), 8'($random(seed)));
    end
    instr_valid = 1'b0;
    stop_test();
  end
endmodule : branch_skip_bitop_exec_tb_top
